// *** design/sem_port_pkg.sv ***
// Purpose: Shared constants and types for the dual-port RAM port controller
// Assumes: 100 MHz sys_clk; timing figures of the fastest speed grade
// Notes:   Cycle counts derive from nanosecond figures, rounded up as minimums
package sem_port_pkg;

   localparam int CLK_NS      = 10;
   localparam int ADDR_W      = 15;
   localparam int DATA_W      = 8;

   // ***************************************************************
   // Timing figures in ns
   // ***************************************************************
   localparam int T_WP_NS     = 12;   // Least write pulse
   localparam int T_WZ_NS     = 10;   // Longest output float after strobe
   localparam int T_DW_NS     = 10;   // Least data setup to write end
   localparam int T_DH_NS     = 0;    // Least data_hold_after_write_end
   localparam int T_SWRD_NS   = 5;    // Least flag write to read time
   localparam int T_SAA_NS    = 15;   // Longest flag read access

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up

   localparam int WP_CYC      = cyc_up(T_WP_NS);
   localparam int FLOAT_CYC   = cyc_up(T_WZ_NS) + cyc_up(T_DW_NS);
   localparam int PULSE_CYC   = (WP_CYC > FLOAT_CYC) ? WP_CYC : FLOAT_CYC;
   localparam int HOLD_CYC    = cyc_up(T_DH_NS);
   localparam int SWRD_CYC    = cyc_up(T_SWRD_NS);
   localparam int SAA_CYC     = cyc_up(T_SAA_NS);
   localparam int TMR_W       = 4;

   // ***************************************************************
   // Commands
   // ***************************************************************
   typedef enum logic [1:0] {
      OP_ARRAY_WRITE = 2'h0,
      OP_FLAG_WRITE  = 2'h1,
      OP_FLAG_TAKE   = 2'h2
   } op_e;

   typedef struct packed {
      op_e                op;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  data;
   } cmd_s;

   typedef struct packed {
      logic               granted;
      logic [DATA_W-1:0]  data;
   } rsp_s;

endpackage : sem_port_pkg

// *** design/cycle_timer.sv ***
// Purpose: Down-counter that times one wait of a given number of cycles
// Assumes: load and expired are sampled on the same sys_clk
// Notes:   Loaded with cycles minus one; expired while count is zero
`timescale 1ns/1ps
module cycle_timer
   import sem_port_pkg::*;
#(
   parameter int W = TMR_W
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          load,
   input  wire logic [W-1:0]  value,
   output logic               expired
);

   logic [W-1:0] count;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (count != '0) begin
         count <= count - W'(1);
      end
   end

   assign expired = (count == '0);

endmodule : cycle_timer

// *** design/sem_port_host.sv ***
// Purpose: Drives one port of an asynchronous dual-port RAM for array and
//          flag writes, and flag take with read-back
// Assumes: Pins sampled synchronously; device output float within T_WZ_NS
// Notes:   Output enable stays high during every write
`timescale 1ns/1ps
module sem_port_host
   import sem_port_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input  wire logic           sys_clk,
   input  wire logic           rst,
   input  wire logic           cmd_valid,
   input  wire cmd_s           cmd,
   output logic                cmd_ready,
   output logic                rsp_valid,
   output rsp_s                rsp,
   output logic [AW-1:0]       mem_addr,
   output logic                ce_n,
   output logic                flag_select_n,
   output logic                rw_n,
   output logic                oe_n,
   input  wire logic [DW-1:0]  data_in,
   output logic [DW-1:0]       data_out,
   output logic                data_oe
);

   // ***************************************************************
   // State machine
   // ***************************************************************
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b000_0001,
      ST_SETUP = 7'b000_0010,
      ST_PULSE = 7'b000_0100,
      ST_HOLD  = 7'b000_1000,
      ST_GAP   = 7'b001_0000,
      ST_READ  = 7'b010_0000,
      ST_DONE  = 7'b100_0000
   } state_e;

   state_e              state;
   op_e                 op;
   logic                tmr_load;
   logic [TMR_W-1:0]    tmr_value;
   logic                tmr_expired;
   logic [DW-1:0]       cmd_data_q;

   cycle_timer #(
      .W       (TMR_W)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (tmr_load),
      .value   (tmr_value),
      .expired (tmr_expired)
   );

   always_comb begin
      tmr_load  = 1'b0;
      tmr_value = '0;
      case (state)
         ST_SETUP: begin
            tmr_load  = 1'b1;
            tmr_value = TMR_W'(PULSE_CYC - 1);
         end
         ST_HOLD: begin
            tmr_load  = 1'b1;
            tmr_value = TMR_W'(SWRD_CYC - 1);
         end
         ST_GAP: begin
            tmr_load  = tmr_expired;
            tmr_value = TMR_W'(SAA_CYC - 1);
         end
         default: begin
            tmr_load  = 1'b0;
            tmr_value = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:  if (cmd_valid && cmd_ready) state <= ST_SETUP;
            ST_SETUP: state <= ST_PULSE;
            ST_PULSE: if (tmr_expired) state <= ST_HOLD;
            ST_HOLD:  state <= (op == OP_FLAG_TAKE) ? ST_GAP : ST_DONE;
            ST_GAP:   if (tmr_expired) state <= ST_READ;
            ST_READ:  if (tmr_expired) state <= ST_DONE;
            ST_DONE:  state <= ST_IDLE;
            default:  state <= ST_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Command capture; one request in flight at a time
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_ready <= 1'b0;
      end else if (state == ST_IDLE && cmd_valid && cmd_ready) begin
         cmd_ready <= 1'b0;
      end else if (state == ST_IDLE) begin
         cmd_ready <= 1'b1;
      end
   end

   // Address moves only in idle, where the strobe is high
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         op       <= OP_ARRAY_WRITE;
         mem_addr <= '0;
      end else if (state == ST_IDLE && cmd_valid && cmd_ready) begin
         op       <= cmd.op;
         mem_addr <= cmd.addr[AW-1:0];
      end
   end

   // ***************************************************************
   // Selects: array or flag, never both, fixed for the whole access
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ce_n          <= 1'b1;
         flag_select_n <= 1'b1;
      end else if (state == ST_IDLE && cmd_valid && cmd_ready) begin
         ce_n          <= (cmd.op != OP_ARRAY_WRITE);
         flag_select_n <= (cmd.op == OP_ARRAY_WRITE);
      end else if (state == ST_DONE) begin
         ce_n          <= 1'b1;
         flag_select_n <= 1'b1;
      end
   end

   // Strobe falls after select, so the device keeps its pins floating
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rw_n <= 1'b1;
      end else if (state == ST_SETUP) begin
         rw_n <= 1'b0;
      end else if (state == ST_PULSE && tmr_expired) begin
         rw_n <= 1'b1;
      end
   end

   // Data held one cycle past the strobe rise for margin on hold time
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_out <= '0;
         data_oe  <= 1'b0;
      end else if (state == ST_SETUP) begin
         data_out <= (op == OP_FLAG_TAKE) ? '0 : cmd_data_q;
         data_oe  <= 1'b1;
      end else if (state == ST_HOLD) begin
         data_oe  <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_data_q <= '0;
      end else if (state == ST_IDLE && cmd_valid && cmd_ready) begin
         cmd_data_q <= cmd.data[DW-1:0];
      end
   end

   // Read-back begins only after the write-to-read gap
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         oe_n <= 1'b1;
      end else if (state == ST_GAP && tmr_expired) begin
         oe_n <= 1'b0;
      end else if (state == ST_READ && tmr_expired) begin
         oe_n <= 1'b1;
      end
   end

   // ***************************************************************
   // Answer
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp       <= '0;
      end else if (state == ST_READ && tmr_expired) begin
         rsp_valid    <= 1'b1;
         rsp.data     <= data_in;
         rsp.granted  <= ~data_in[0];
      end else if (state == ST_HOLD && op != OP_FLAG_TAKE) begin
         rsp_valid    <= 1'b1;
         rsp.data     <= cmd_data_q;
         rsp.granted  <= 1'b0;
      end else begin
         rsp_valid    <= 1'b0;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence write_start;
      $fell(rw_n);
   endsequence

   sequence flag_write_end;
      $rose(rw_n) && !flag_select_n;
   endsequence

   AST_ADDR_CHANGE: assert property ($changed(mem_addr) |-> rw_n)
      else $error("address moved while strobe low");

   AST_SELECT_EXCL: assert property (ce_n || flag_select_n)
      else $error("array and flag selected together");

   AST_SELECT_STABLE: assert property (write_start |->
      ($stable(ce_n) && $stable(flag_select_n)) throughout
      (!rw_n ##1 !rw_n ##1 rw_n))
      else $error("selection changed during write");

   AST_NO_BUS_FIGHT: assert property (data_oe |-> oe_n)
      else $error("data driven while output enabled");

   AST_PULSE_WIDTH: assert property (write_start |->
      (!rw_n && data_oe)[*2] ##1 rw_n)
      else $error("write pulse length wrong");

   AST_DATA_HOLD: assert property ($rose(rw_n) |->
      data_oe && $stable(data_out))
      else $error("data released at write end");

   AST_READ_GAP: assert property (flag_write_end |->
      oe_n[*2])
      else $error("flag read too soon after write");

   AST_FLAG_CE_HIGH: assert property ($fell(flag_select_n) |->
      ce_n throughout (##[1:12] $rose(flag_select_n)))
      else $error("array enable low during flag access");

   AST_ONE_REQUEST: assert property (state != ST_IDLE |->
      !cmd_ready)
      else $error("second request accepted in flight");

   AST_TAKE_ANSWER: assert property ($fell(oe_n) |->
      ##2 rsp_valid && (rsp.granted != $past(data_in[0])))
      else $error("flag answer missing or wrong");

endmodule : sem_port_host

// *** dv/dp_ram_model.sv ***
// Purpose: Device side of one RAM port plus port B flag requests
// Assumes: Port B only writes flags; reads settle after ACC_NS
// Notes:   A released data bus shows the inverse of the host byte
`timescale 1ns/1ps
module dp_ram_model
   import sem_port_pkg::*;
#(
   parameter int ACC_NS = T_SAA_NS
) (
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic              ce_n,
   input  wire logic              flag_select_n,
   input  wire logic              rw_n,
   input  wire logic              oe_n,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe,
   input  wire logic              b_flag_n,
   input  wire logic [2:0]        b_idx,
   input  wire logic              b_bit,
   output logic      [DATA_W-1:0] data_in
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   int                own [0:7] = '{default: 0};  // 1 port A, 2 port B
   logic              rd_ok;
   logic [DATA_W-1:0] rd_val;
   wire               wr_arr = !ce_n && !rw_n;
   wire               wr_flg = !flag_select_n && !rw_n;
   wire               rd_en  = rw_n && !oe_n && !(ce_n && flag_select_n);
   wire [DATA_W-1:0]  bus    = data_oe ? data_out : ~data_out;

   // First finished request wins; a same-instant pair still yields one
   task automatic claim(input int idx, input int port, input logic v);
      if (v == 1'b1 && own[idx] == port) own[idx] = 0;
      else if (v == 1'b0 && own[idx] == 0) own[idx] = port;
   endtask : claim

   always @(negedge wr_arr) mem[mem_addr] = bus;
   always @(negedge wr_flg)
      claim(mem_addr[2:0], 1, bus[0]);
   always @(posedge b_flag_n) claim(b_idx, 2, b_bit);
   always_comb
      rd_val = !ce_n ? mem[mem_addr] : {DATA_W{own[mem_addr[2:0]] != 1}};
   // Read data stays unusable until the access time has run out
   assign #(ACC_NS) rd_ok = rd_en;
   assign data_in = rd_ok ? rd_val : bus;
endmodule : dp_ram_model

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the flag and array write controller
// Assumes: Device model answers flag reads within 15 ns
// Notes:   Port B of the device is driven from here for flag races
`timescale 1ns/1ps
module testbench
   import sem_port_pkg::*;
;
   logic              sys_clk, rst, cmd_valid, cmd_ready, rsp_valid;
   logic              ce_n, flag_select_n, rw_n, oe_n, data_oe;
   // Starts high so the model sees no false port B request at time zero
   logic              b_flag_n = 1'b1;
   logic              b_bit, racing;
   logic [2:0]        b_idx;
   logic [ADDR_W-1:0] mem_addr;
   logic [DATA_W-1:0] data_in, data_out;
   cmd_s              cmd;
   rsp_s              rsp;
   int                miscompares, total_checks, seed, cycles;
   int                exp_own [0:7];
   logic [DATA_W-1:0] exp_mem [int];

   sem_port_host dut (.sys_clk, .rst, .cmd_valid, .cmd, .cmd_ready,
      .rsp_valid, .rsp, .mem_addr, .ce_n, .flag_select_n, .rw_n, .oe_n,
      .data_in, .data_out, .data_oe);
   dp_ram_model ram (.mem_addr, .ce_n, .flag_select_n, .rw_n, .oe_n,
      .data_out, .data_oe, .b_flag_n, .b_idx, .b_bit, .data_in);

   // ****************
   // Checking helpers
   // ****************
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic void claim(input int idx, input int port, logic v);
      if (v == 1'b1 && exp_own[idx] == port) exp_own[idx] = 0;
      else if (v == 1'b0 && exp_own[idx] == 0) exp_own[idx] = port;
   endfunction : claim

   task automatic b_write(input int idx, input logic v);
      b_idx = 3'(idx);
      b_bit = v;
      b_flag_n = 1'b0;
      @(negedge sys_clk);
      b_flag_n = 1'b1;
      claim(idx, 2, v);
   endtask : b_write

   // Junk requests ride cmd_valid while busy; none may be taken
   task automatic do_cmd(input op_e op, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      int                n, low, lw;
      logic [DATA_W-1:0] rd;
      n = 0;
      low = 0;
      lw = 0;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      cmd_valid = 1'b1;
      cmd = '{op, a, d};
      for (n = 0; n < 12 && rsp_valid !== 1'b1; n++) begin
         if (n > 0) begin
            cmd_valid = 1'($random(seed));
            cmd = cmd_s'(20'($random(seed)));
         end
         @(negedge sys_clk);
         check("busy", {cmd_ready, rw_n | oe_n, oe_n | !data_oe,
            !(ram.rd_ok && data_oe)}, 4'h7);
         check("sel", {ce_n | flag_select_n,
            op == OP_ARRAY_WRITE || ce_n}, 2'h3);
         if (!ce_n || !flag_select_n) check("addr", mem_addr, a);
         if (rw_n === 1'b0) begin
            low++;
            lw = n;
         end
         if (oe_n === 1'b0) check("gap", n - lw > SWRD_CYC, 1'b1);
      end
      cmd_valid = 1'b0;
      check("latency", n - 1, op == OP_FLAG_TAKE ? 7 : 4);
      check("pulse", low, PULSE_CYC);
      if (op == OP_ARRAY_WRITE) exp_mem[int'(a)] = d;
      else if (!racing) claim(a[2:0], 1, op == OP_FLAG_TAKE ? 1'b0 : d[0]);
      rd = (op != OP_FLAG_TAKE) ? d : {DATA_W{exp_own[a[2:0]] != 1}};
      check("rsp", rsp, {op == OP_FLAG_TAKE && !rd[0], rd});
      if (op == OP_ARRAY_WRITE) check("mem", ram.mem[a], d);
      else if (!racing)
         check("own", ram.own[a[2:0]], exp_own[a[2:0]]);
      @(negedge sys_clk);
      check("rsp end", rsp_valid, 1'b0);
   endtask : do_cmd

   // *************
   // Main sequence
   // *************
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      {b_flag_n, b_bit, b_idx, racing} = 6'b10_0000;
      seed = 65267;
      foreach (exp_own[i]) exp_own[i] = 0;
      repeat (16) @(negedge sys_clk);
      check("reset", {cmd_ready, rsp_valid, ce_n, flag_select_n, rw_n, oe_n,
         data_oe, mem_addr}, {7'b001_1110, 15'h0000});
      rst = 1'b0;
      @(negedge sys_clk);
      do_cmd(OP_ARRAY_WRITE, '1, 8'hA5);
      repeat (12) do_cmd(OP_ARRAY_WRITE, ADDR_W'($random(seed)),
                         DATA_W'($random(seed)));
      for (int i = 0; i < 8; i++) begin
         do_cmd(OP_FLAG_TAKE, ADDR_W'(i), 8'h00);
         do_cmd(OP_FLAG_WRITE, ADDR_W'(i), 8'hFF);
      end
      b_write(3, 1'b0);
      do_cmd(OP_FLAG_TAKE, 15'h0003, 8'h00);
      b_write(3, 1'b1);
      do_cmd(OP_FLAG_TAKE, 15'h0003, 8'h00);
      b_write(3, 1'b0);
      check("keep", ram.own[3], exp_own[3]);
      do_cmd(OP_FLAG_WRITE, 15'h0003, 8'h01);
      // Both ports end their flag writes in the same instant
      racing = 1'b1;
      b_idx = 3'h5;
      b_bit = 1'b0;
      b_flag_n = 1'b0;
      fork
         do_cmd(OP_FLAG_WRITE, 15'h0005, 8'h00);
         begin
            @(posedge rw_n);
            b_flag_n = 1'b1;
         end
      join
      check("one", ram.own[5] == 1 || ram.own[5] == 2, 1'b1);
      exp_own[5] = ram.own[5];
      racing = 1'b0;
      do_cmd(OP_FLAG_TAKE, 15'h0005, 8'h00);
      foreach (exp_mem[k]) check("array", ram.mem[k], exp_mem[k]);
      print_verdict();
   end
endmodule : testbench
